//--- sct_pkg.sv
package sct_pkg;

	// -------------------------------------------------------------------------
	// register map (byte addresses)
	// -------------------------------------------------------------------------
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_CYCLE_BASE = 12'h010;
	localparam logic [11:0] ADDR_OFFSET_BASE = 12'h020;
	localparam logic [11:0] ADDR_FORCEOFF_BASE = 12'h040;
	localparam logic [11:0] ADDR_HOLDREL = 12'h060;
	localparam logic [11:0] ADDR_MAXDWELL = 12'h064;
	localparam logic [11:0] ADDR_DAILY_REF = 12'h068;
	localparam logic [11:0] ADDR_ABS_REF = 12'h06c;
	localparam logic [11:0] ADDR_DST = 12'h070;
	localparam logic [11:0] ADDR_CALLS = 12'h074;
	localparam logic [11:0] ADDR_TOD = 12'h078;

	// -------------------------------------------------------------------------
	// reset values and limits
	// -------------------------------------------------------------------------
	localparam logic [7:0] CYCLE_MIN = 8'h28;
	localparam logic [7:0] CYCLE_RESET = 8'h3c;
	localparam logic [6:0] DWELL_MIN = 7'h01;
	localparam logic [6:0] DWELL_MAX = 7'h63;
	localparam logic [6:0] DWELL_RESET = 7'h0a;
	localparam logic [10:0] MIN_PER_DAY = 11'h05a0;
	localparam logic [5:0] SEC_PER_MIN = 6'h3c;
	localparam int LINE_HZ = 60;

	// -------------------------------------------------------------------------
	// modes, sync methods and controller states
	// -------------------------------------------------------------------------
	typedef enum logic [1:0] {
		SCT_MODE_SEMI = 2'h0,
		SCT_MODE_FIXED = 2'h1,
		SCT_MODE_FREE = 2'h3
	} sct_mode_t;

	typedef enum logic [1:0] {
		SCT_SYNC_DWELL = 2'h0,
		SCT_SYNC_DWELL_INT = 2'h1,
		SCT_SYNC_SHORT = 2'h3
	} sct_sync_t;

	typedef enum logic [1:0] {
		SCT_ST_FREE = 2'h0,
		SCT_ST_SYNC = 2'h1,
		SCT_ST_COORD = 2'h3
	} sct_state_t;

endpackage

//--- sct_line_prescaler.sv
`timescale 1ns/1ps
module sct_line_prescaler #(
	parameter int DIV = 60
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic line_edge,
	output logic sec_tick
);
	localparam logic [6:0] DIV_LAST = 7'(DIV - 1);

	typedef struct packed {
		logic [6:0] cnt;
		logic tick;
	} sct_pre_t;

	sct_pre_t r;
	sct_pre_t next_r;

	always_comb begin
		next_r = r;
		next_r.tick = 1'b0;
		if (line_edge) begin
			if (r.cnt == DIV_LAST) begin
				next_r.cnt = 7'h00;
				next_r.tick = 1'b1;
			end else begin
				next_r.cnt = r.cnt + 7'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign sec_tick = r.tick;
endmodule // sct_line_prescaler

//--- sct_coord.sv
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module sct_coord #(
	parameter int NPH = 8,
	parameter int NCYC = 4,
	parameter int NFO = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic line_edge,
	input wire logic sync_pulse,
	input wire logic [NPH-1:0] det_call,
	input wire logic [NPH-1:0] phase_green,
	output logic [NPH-1:0] force_off,
	output logic [NPH-1:0] max_recall,
	output logic [NPH-1:0] cont_call,
	output logic [NPH-1:0] held_call,
	output logic max_inhibit,
	output logic coord_hold
);
	// -------------------------------------------------------------------------
	// state
	// -------------------------------------------------------------------------
	typedef struct packed {
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic [1:0] mode_sel;
		logic mode_ovr;
		logic [1:0] sys_mode;
		logic [1:0] sync_sel;
		logic [1:0] cyc_ovr;
		logic cyc_ovr_en;
		logic [1:0] off_ovr;
		logic off_ovr_en;
		logic [1:0] sys_cyc;
		logic [1:0] sys_off;
		logic abs_en;
		logic [NPH-1:0] coord_ph;
		logic [NPH-1:0] recall_sel;
		logic [NCYC-1:0][7:0] cyc_len;
		logic [NCYC-1:0][7:0] offset;
		logic [NFO-1:0][7:0] fo_pt;
		logic [7:0] hold_rel;
		logic [6:0] max_dwell;
		logic [10:0] daily_ref;
		logic [8:0] abs_day;
		logic [10:0] abs_min;
		logic [8:0] dst_on_day;
		logic [8:0] dst_off_day;
		logic dst;
		logic [5:0] sec;
		logic [10:0] minute;
		logic [8:0] day;
		logic [7:0] ctimer;
		logic [1:0] act_cyc;
		logic [6:0] dwell_cnt;
		logic sync_req;
		logic [NPH-1:0] calls;
		sct_pkg::sct_state_t st;
		logic [NPH-1:0] fo;
		logic [NPH-1:0] mrec;
		logic [NPH-1:0] ccall;
		logic minh;
		logic hold;
	} sct_state_s_t;

	sct_state_s_t r;
	sct_state_s_t next_r;

	logic sec_tick;

	sct_line_prescaler #(.DIV(sct_pkg::LINE_HZ)) u_pre (
		.clk(clk),
		.nrst(nrst),
		.line_edge(line_edge),
		.sec_tick(sec_tick)
	);

	function automatic logic [7:0] clamp_cyc(input logic [7:0] v);
		clamp_cyc = (v < sct_pkg::CYCLE_MIN) ? sct_pkg::CYCLE_MIN : v;
	endfunction

	// -------------------------------------------------------------------------
	// next state
	// -------------------------------------------------------------------------
	logic [1:0] mode;
	logic [1:0] cyc_idx;
	logic [1:0] off_idx;
	logic [7:0] len;
	logic [7:0] tgt;
	logic [7:0] diff;
	logic coord_green;
	logic side_demand;
	logic wr;
	logic rd;
	logic cyc_end;
	logic resync;
	logic free_now;
	integer i;

	always_comb begin
		next_r = r;
		mode = r.mode_ovr ? r.mode_sel : r.sys_mode;
		cyc_idx = r.cyc_ovr_en ? r.cyc_ovr : r.sys_cyc;
		off_idx = r.off_ovr_en ? r.off_ovr : r.sys_off;
		len = clamp_cyc(r.cyc_len[r.act_cyc]);
		tgt = r.offset[off_idx];
		diff = 8'h00;
		coord_green = |(phase_green & r.coord_ph);
		side_demand = |((r.calls | det_call) & ~r.coord_ph);
		free_now = (mode == sct_pkg::SCT_MODE_FREE);
		wr = psel && penable && pwrite && !r.ready;
		rd = psel && penable && !pwrite && !r.ready;
		cyc_end = 1'b0;
		resync = 1'b0;

		// apb: one wait state, answer in the cycle after access begins
		next_r.ready = psel && penable && !r.ready;
		next_r.err = 1'b0;
		if (wr) begin
			case (paddr)
				sct_pkg::ADDR_CTRL: begin
					next_r.mode_sel = pwdata[1:0];
					next_r.mode_ovr = pwdata[2];
					next_r.sync_sel = pwdata[4:3];
					next_r.cyc_ovr = pwdata[6:5];
					next_r.cyc_ovr_en = pwdata[7];
					next_r.off_ovr = pwdata[9:8];
					next_r.off_ovr_en = pwdata[10];
					next_r.sys_mode = pwdata[12:11];
					next_r.sys_cyc = pwdata[14:13];
					next_r.sys_off = pwdata[16:15];
					next_r.abs_en = pwdata[17];
				end
				sct_pkg::ADDR_HOLDREL: next_r.hold_rel = pwdata[7:0];
				sct_pkg::ADDR_MAXDWELL: begin
					next_r.max_dwell = (pwdata[6:0] < sct_pkg::DWELL_MIN) ? sct_pkg::DWELL_MIN :
						(pwdata[6:0] > sct_pkg::DWELL_MAX) ? sct_pkg::DWELL_MAX : pwdata[6:0];
				end
				sct_pkg::ADDR_DAILY_REF: next_r.daily_ref = pwdata[10:0];
				sct_pkg::ADDR_ABS_REF: begin
					next_r.abs_min = pwdata[10:0];
					next_r.abs_day = pwdata[24:16];
				end
				sct_pkg::ADDR_DST: begin
					next_r.dst_on_day = pwdata[8:0];
					next_r.dst_off_day = pwdata[24:16];
				end
				sct_pkg::ADDR_CALLS: begin
					next_r.coord_ph = pwdata[NPH-1:0];
					next_r.recall_sel = pwdata[NPH+15:16];
				end
				sct_pkg::ADDR_TOD: begin
					next_r.minute = pwdata[10:0];
					next_r.day = pwdata[24:16];
					next_r.sec = 6'h00;
				end
				default: begin
					if (paddr[11:4] == sct_pkg::ADDR_CYCLE_BASE[11:4] && int'(paddr[3:2]) < NCYC) begin
						next_r.cyc_len[paddr[3:2]] = clamp_cyc(pwdata[7:0]);
					end else if (paddr[11:4] == sct_pkg::ADDR_OFFSET_BASE[11:4]) begin
						next_r.offset[paddr[3:2]] = pwdata[7:0];
					end else if (paddr[11:5] == sct_pkg::ADDR_FORCEOFF_BASE[11:5]) begin
						next_r.fo_pt[paddr[4:2]] = pwdata[7:0];
					end else begin
						next_r.err = 1'b1;
					end
				end
			endcase
		end
		next_r.rdata = 32'h0000_0000;
		if (rd) begin
			case (paddr)
				sct_pkg::ADDR_CTRL: next_r.rdata = {14'h0000, r.abs_en, r.sys_off, r.sys_cyc,
					r.sys_mode, r.off_ovr_en, r.off_ovr, r.cyc_ovr_en, r.cyc_ovr, r.sync_sel,
					r.mode_ovr, r.mode_sel};
				sct_pkg::ADDR_STATUS: next_r.rdata = {4'h0, r.dst, r.st, r.act_cyc, r.dwell_cnt,
					r.ctimer, r.calls};
				sct_pkg::ADDR_HOLDREL: next_r.rdata = {24'h00_0000, r.hold_rel};
				sct_pkg::ADDR_MAXDWELL: next_r.rdata = {25'h000_0000, r.max_dwell};
				sct_pkg::ADDR_DAILY_REF: next_r.rdata = {21'h00_0000, r.daily_ref};
				sct_pkg::ADDR_ABS_REF: next_r.rdata = {7'h00, r.abs_day, 5'h00, r.abs_min};
				sct_pkg::ADDR_DST: next_r.rdata = {7'h00, r.dst_off_day, 7'h00, r.dst_on_day};
				sct_pkg::ADDR_CALLS: next_r.rdata = {8'h00, r.recall_sel, 8'h00, r.coord_ph};
				sct_pkg::ADDR_TOD: next_r.rdata = {r.sec, 1'b0, r.day, 5'h00, r.minute};
				default: begin
					if (paddr[11:4] == sct_pkg::ADDR_CYCLE_BASE[11:4] && int'(paddr[3:2]) < NCYC) begin
						next_r.rdata = {24'h00_0000, r.cyc_len[paddr[3:2]]};
					end else if (paddr[11:4] == sct_pkg::ADDR_OFFSET_BASE[11:4]) begin
						next_r.rdata = {24'h00_0000, r.offset[paddr[3:2]]};
					end else if (paddr[11:5] == sct_pkg::ADDR_FORCEOFF_BASE[11:5]) begin
						next_r.rdata = {24'h00_0000, r.fo_pt[paddr[4:2]]};
					end else begin
						next_r.err = 1'b1;
					end
				end
			endcase
		end

		// ---------------------------------------------------------------------
		// time of day
		// ---------------------------------------------------------------------
		if (sec_tick) begin
			if (r.sec == sct_pkg::SEC_PER_MIN - 6'h01) begin
				next_r.sec = 6'h00;
				if (r.minute == sct_pkg::MIN_PER_DAY - 11'h001) begin
					next_r.minute = 11'h000;
					next_r.day = r.day + 9'h001;
				end else begin
					next_r.minute = r.minute + 11'h001;
				end
				// dst moves clock one hour: forward at 2:00 on the on day, back at 3:00 on the off day
				if (r.minute == 11'h077 && r.day == r.dst_on_day && !r.dst) begin
					next_r.dst = 1'b1;
					next_r.minute = 11'h0b4;
				end else if (r.minute == 11'h0b3 && r.day == r.dst_off_day && r.dst) begin
					next_r.dst = 1'b0;
					next_r.minute = 11'h078;
				end
				if (r.minute + 11'h001 == r.daily_ref ||
					(r.minute == sct_pkg::MIN_PER_DAY - 11'h001 && r.daily_ref == 11'h000)) begin
					resync = 1'b1;
				end
				if (r.abs_en && r.minute + 11'h001 == r.abs_min && r.day == r.abs_day) begin
					resync = 1'b1;
				end
			end else begin
				next_r.sec = r.sec + 6'h01;
			end
		end

		// ---------------------------------------------------------------------
		// cycle timer and offset sync
		// ---------------------------------------------------------------------
		if (sync_pulse) begin
			next_r.sync_req = 1'b1;
		end
		case (r.st)
			sct_pkg::SCT_ST_FREE: begin
				next_r.ctimer = 8'h00;
				next_r.act_cyc = cyc_idx;
				// restart from free only at the start of a minute
				if (!free_now && sec_tick && r.sec == sct_pkg::SEC_PER_MIN - 6'h01) begin
					next_r.st = sct_pkg::SCT_ST_COORD;
				end
			end
			sct_pkg::SCT_ST_SYNC: begin
				diff = 8'(r.ctimer - tgt);
				if (free_now) begin
					next_r.st = sct_pkg::SCT_ST_FREE;
				end else if (r.ctimer == tgt) begin
					next_r.st = sct_pkg::SCT_ST_COORD;
					next_r.dwell_cnt = 7'h00;
				end else if (sec_tick) begin
					if (r.sync_sel == sct_pkg::SCT_SYNC_SHORT && diff < (len >> 1)) begin
						next_r.ctimer = (r.ctimer == 8'h00) ? len - 8'h01 : r.ctimer;
					end else if (r.sync_sel == sct_pkg::SCT_SYNC_SHORT) begin
						next_r.ctimer = (r.ctimer + 8'h02 >= len) ? 8'h00 : r.ctimer + 8'h02;
					end else if (coord_green && !(r.sync_sel == sct_pkg::SCT_SYNC_DWELL_INT &&
						r.dwell_cnt >= r.max_dwell)) begin
						next_r.dwell_cnt = r.dwell_cnt + 7'h01;
					end else begin
						next_r.ctimer = (r.ctimer + 8'h01 >= len) ? 8'h00 : r.ctimer + 8'h01;
						next_r.dwell_cnt = 7'h00;
					end
				end
			end
			sct_pkg::SCT_ST_COORD: begin
				if (free_now) begin
					next_r.st = sct_pkg::SCT_ST_FREE;
				end else if (sec_tick) begin
					if (r.ctimer + 8'h01 >= len) begin
						cyc_end = 1'b1;
						next_r.ctimer = 8'h00;
						next_r.act_cyc = cyc_idx;
					end else begin
						next_r.ctimer = r.ctimer + 8'h01;
					end
				end
				if (resync) begin
					next_r.ctimer = 8'h00;
				end
				if (r.sync_req && cyc_end) begin
					next_r.sync_req = 1'b0;
					next_r.st = sct_pkg::SCT_ST_SYNC;
				end
			end
			default: next_r.st = sct_pkg::SCT_ST_FREE;
		endcase

		// ---------------------------------------------------------------------
		// phase supervision
		// ---------------------------------------------------------------------
		for (i = 0; i < NPH; i++) begin
			if (phase_green[i]) begin
				next_r.calls[i] = 1'b0;
			end
			if (det_call[i] && !r.coord_ph[i]) begin
				next_r.calls[i] = 1'b1;
			end
			// force-off point i belongs to phase i's split
			next_r.fo[i] = (r.st != sct_pkg::SCT_ST_FREE) && !free_now && (r.ctimer == r.fo_pt[i])
				&& phase_green[i] && !r.fo[i] && (!r.coord_ph[i] || side_demand);
		end
		next_r.hold = (r.st != sct_pkg::SCT_ST_FREE) && !free_now &&
			(r.ctimer < r.hold_rel || !side_demand);
		next_r.minh = (r.st != sct_pkg::SCT_ST_FREE) && !free_now;
		next_r.ccall = next_r.minh ? r.coord_ph : '0;
		case (mode)
			sct_pkg::SCT_MODE_SEMI: next_r.mrec = r.coord_ph | r.recall_sel;
			sct_pkg::SCT_MODE_FIXED: next_r.mrec = '1;
			default: next_r.mrec = r.recall_sel;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
			r.cyc_len <= {NCYC{sct_pkg::CYCLE_RESET}};
			r.max_dwell <= sct_pkg::DWELL_RESET;
			r.hold_rel <= 8'h00;
		end else begin
			r <= next_r;
		end
	end

	assign prdata = r.rdata;
	assign pready = r.ready;
	assign pslverr = r.err;
	assign force_off = r.fo;
	assign max_recall = r.mrec;
	assign cont_call = r.ccall;
	assign held_call = r.calls;
	assign max_inhibit = r.minh;
	assign coord_hold = r.hold;
endmodule // sct_coord

//--- sct_coord_props.sv
`timescale 1ns/1ps
module sct_coord_props #(
	parameter int NPH = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NPH-1:0] phase_green,
	input wire logic [NPH-1:0] force_off,
	input wire logic [NPH-1:0] held_call,
	input wire logic max_inhibit
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// ---------------------------------------------------------------
	// register bus and coordination outputs
	// ---------------------------------------------------------------
	a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready not one cycle after access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_unmapped_err: assert property (psel && penable && !pready && paddr > 12'h078 |=> pslverr)
		else $error("unmapped access not refused");
	a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
		else $error("refused read returned data");
	a_force_green: assert property ((force_off & ~$past(phase_green)) == '0)
		else $error("force-off on a phase that was not green");
	a_force_pulse: assert property ((force_off & $past(force_off)) == '0)
		else $error("force-off longer than one cycle");
	a_force_coord: assert property (|force_off |-> max_inhibit)
		else $error("force-off issued while not coordinating");
	a_held_keep: assert property ((($past(held_call) & ~$past(phase_green)) & ~held_call) == '0)
		else $error("held call dropped before its phase was served");
endmodule // sct_coord_props

bind sct_coord sct_coord_props #(.NPH(NPH)) i_props (
	.clk(clk),
	.nrst(nrst),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.phase_green(phase_green),
	.force_off(force_off),
	.held_call(held_call),
	.max_inhibit(max_inhibit)
);

//--- sct_seq_model.sv
`timescale 1ns/1ps
module sct_seq_model #(
	parameter int NPH = 8,
	parameter int MAXG = 200
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [NPH-1:0] force_off,
	input wire logic [NPH-1:0] max_recall,
	input wire logic [NPH-1:0] cont_call,
	input wire logic [NPH-1:0] held_call,
	input wire logic max_inhibit,
	input wire logic [7:0] clear_len,
	output logic [NPH-1:0] phase_green
);
	// ---------------------------------------------------------------
	// single ring: one green phase, clearance of clear_len + 1 cycles
	// ---------------------------------------------------------------
	int cur;
	int cnt;
	int clr;
	logic [NPH-1:0] dem;
	assign dem = max_recall | cont_call | held_call;
	function automatic int next_ph(input int c, input logic [NPH-1:0] d);
		for (int k = 1; k <= NPH; k++) begin
			if (d[(c + k) % NPH]) return (c + k) % NPH;
		end
		return c;
	endfunction
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cur <= 1;
			cnt <= 0;
			clr <= 1;
			phase_green <= '0;
		end else if (clr != 0) begin
			clr <= clr - 1;
			cnt <= 0;
			if (clr == 1) phase_green <= NPH'(1) << cur;
		end else begin
			cnt <= cnt + 1;
			// own max green only counts when the coordinator does not inhibit it
			if (force_off[cur] || (!max_inhibit && cnt >= MAXG && next_ph(cur, dem) != cur)) begin
				phase_green <= '0;
				cur <= next_ph(cur, dem);
				clr <= int'(clear_len) + 1;
			end
		end
	end
endmodule // sct_seq_model

//--- signal_coordination_timer_test.sv
`timescale 1ns/1ps
module signal_coordination_timer_test;
	typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} sct_note_t;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, line_edge, sync_pulse;
	logic max_inhibit, coord_hold;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, val;
	logic [7:0] det_call, phase_green, force_off, max_recall, cont_call, held_call, clear_len;
	logic [15:0] seed;
	int errors, n_compared, cyc;
	sct_note_t q[$];
	sct_coord i_sct_coord (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .line_edge(line_edge), .sync_pulse(sync_pulse), .det_call(det_call),
		.phase_green(phase_green), .force_off(force_off), .max_recall(max_recall),
		.cont_call(cont_call), .held_call(held_call), .max_inhibit(max_inhibit),
		.coord_hold(coord_hold));
	sct_seq_model i_sct_seq_model (.clk(clk), .nrst(nrst), .force_off(force_off),
		.max_recall(max_recall), .cont_call(cont_call), .held_call(held_call),
		.max_inhibit(max_inhibit), .clear_len(clear_len), .phase_green(phase_green));
	// ---------------------------------------------------------------
	// clock, line time base, timeout, answer monitor
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		line_edge <= ~line_edge;
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			errors++;
			end_sim();
		end
	end
	always @(negedge clk) begin
		if (pready === 1'b1) begin
			if (q.size() == 0) begin
				errors++;
				$display("unexpected at %0t: answer without request", $time);
			end else cmp_apb(q.pop_front());
		end
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task cmp_apb(input sct_note_t n);
		n_compared++;
		if (((prdata & n.m) !== (n.d & n.m)) || (pslverr !== n.e)) begin
			errors++;
			$display("unexpected at %0t: read %h err %b exp %h", $time, prdata, pslverr, n.d);
		end
	endtask
	task cmp_out(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		q.push_back('{d: d, m: (w ? 32'h0000_0000 : m), e: e});
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0000_0000, 1'b0);
	endtask
	task poll_state(input logic [1:0] s);
		for (int k = 0; k < 400; k++) begin
			apb(1'b0, sct_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0000_0000, 1'b0);
			if (rd[26:25] === s) break;
			repeat (40) @(posedge clk);
		end
		cmp_out(rd[26:25], s, "state");
	endtask
	task sync_test(input logic [31:0] c);
		wr(sct_pkg::ADDR_CTRL, c);
		@(posedge clk);
		sync_pulse <= 1'b1;
		@(posedge clk);
		sync_pulse <= 1'b0;
		poll_state(sct_pkg::SCT_ST_SYNC);
		poll_state(sct_pkg::SCT_ST_COORD);
		apb(1'b0, sct_pkg::ADDR_STATUS, 32'h0000_0200, 32'h0000_ff00, 1'b0);
	endtask
	task end_sim();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		{nrst, psel, penable, pwrite, line_edge, sync_pulse} = 6'h00;
		{paddr, pwdata, det_call, clear_len, rd} = '0;
		{errors, n_compared, cyc} = '0;
		seed = 16'h1c8f;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		for (int n = 0; n < 4; n++) begin
			apb(1'b0, sct_pkg::ADDR_CYCLE_BASE + 12'(4 * n), 32'(sct_pkg::CYCLE_RESET),
				32'h0000_00ff, 1'b0);
		end
		apb(1'b0, sct_pkg::ADDR_MAXDWELL, 32'(sct_pkg::DWELL_RESET), 32'h0000_007f, 1'b0);
		apb(1'b0, sct_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0600_0000, 1'b0);
		$display("test reset values done");
		seed = lfsr(seed);
		for (int n = 0; n < 3; n++) begin
			val = (n == 0) ? 32'h0000_0010 : (n == 1) ? 32'h0000_00ff : 32'h28 + 32'(seed % 216);
			wr(sct_pkg::ADDR_CYCLE_BASE + 12'(4 * n), val);
			apb(1'b0, sct_pkg::ADDR_CYCLE_BASE + 12'(4 * n),
				(n == 0) ? 32'(sct_pkg::CYCLE_MIN) : val, 32'h0000_00ff, 1'b0);
		end
		wr(sct_pkg::ADDR_MAXDWELL, 32'h0000_0000);
		apb(1'b0, sct_pkg::ADDR_MAXDWELL, 32'(sct_pkg::DWELL_MIN), 32'h0000_007f, 1'b0);
		wr(sct_pkg::ADDR_MAXDWELL, 32'h0000_0064);
		apb(1'b0, sct_pkg::ADDR_MAXDWELL, 32'(sct_pkg::DWELL_MAX), 32'h0000_007f, 1'b0);
		apb(1'b1, 12'h100, 32'hffff_ffff, 32'h0000_0000, 1'b1);
		apb(1'b0, 12'h100, 32'h0000_0000, 32'hffff_ffff, 1'b1);
		$display("test configuration done");
		wr(sct_pkg::ADDR_CYCLE_BASE, 32'h0000_0028);
		for (int n = 0; n < 8; n++) wr(sct_pkg::ADDR_FORCEOFF_BASE + 12'(4 * n), 32'(4 * n + 6));
		wr(sct_pkg::ADDR_CALLS, 32'h0000_0002);
		@(posedge clk);
		sync_pulse <= 1'b1;
		@(posedge clk);
		sync_pulse <= 1'b0;
		wr(sct_pkg::ADDR_CTRL, 32'h0000_0484);
		poll_state(sct_pkg::SCT_ST_COORD);
		@(negedge clk);
		cmp_out(max_inhibit, 1'b1, "inhibit");
		cmp_out(max_recall & 8'h02, 8'h02, "recall");
		cmp_out(cont_call & 8'h02, 8'h02, "call");
		cmp_out(coord_hold, 1'b1, "hold");
		repeat (3) begin
			apb(1'b0, sct_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0000_0000, 1'b0);
			cmp_out(rd[15:8] < 8'h28, 1'b1, "timer");
		end
		clear_len <= 8'h28;
		@(posedge clk);
		det_call <= 8'h08;
		repeat (2) @(posedge clk);
		det_call <= 8'h00;
		repeat (2) @(negedge clk);
		cmp_out(held_call[3], 1'b1, "held");
		cmp_out(coord_hold, 1'b0, "released");
		for (int k = 0; k < 20000 && phase_green[3] !== 1'b1; k++) @(negedge clk);
		cmp_out(phase_green[3], 1'b1, "served");
		repeat (3) @(negedge clk);
		cmp_out(held_call[3], 1'b0, "cleared");
		$display("test semi-actuated done");
		wr(sct_pkg::ADDR_MAXDWELL, 32'h0000_0001);
		wr(sct_pkg::ADDR_OFFSET_BASE, 32'h0000_0002);
		sync_test(32'h0000_048c);
		sync_test(32'h0000_049c);
		$display("test offset sync done");
		wr(sct_pkg::ADDR_CTRL, 32'h0000_0485);
		for (int k = 0; k < 20000 && max_recall !== 8'hff; k++) @(negedge clk);
		cmp_out(max_recall, 8'hff, "fixed recall");
		$display("test fixed cycle done");
		wr(sct_pkg::ADDR_CTRL, 32'h0000_0487);
		poll_state(sct_pkg::SCT_ST_FREE);
		@(negedge clk);
		cmp_out(max_inhibit, 1'b0, "free inhibit");
		cmp_out(coord_hold, 1'b0, "free hold");
		$display("test free done");
		end_sim();
	end
endmodule // signal_coordination_timer_test
